/* File: verilog/gdis_pkg.sv */
// Package: constants and types of the instrument bus interface and status block
package gdis_pkg;

  // ==========================================================
  // Interface message codes, parity bit masked off
  localparam logic [6:0] GDIS_MSG_GTL = 7'h01;
  localparam logic [6:0] GDIS_MSG_SDC = 7'h04;
  localparam logic [6:0] GDIS_MSG_GET = 7'h08;
  localparam logic [6:0] GDIS_MSG_LLO = 7'h11;
  localparam logic [6:0] GDIS_MSG_DCL = 7'h14;
  localparam logic [6:0] GDIS_MSG_SPE = 7'h18;
  localparam logic [6:0] GDIS_MSG_SPD = 7'h19;
  localparam logic [6:0] GDIS_MSG_UNL = 7'h3F;
  localparam logic [6:0] GDIS_MSG_UNT = 7'h5F;
  localparam logic [1:0] GDIS_GRP_LISTEN = 2'h1;
  localparam logic [1:0] GDIS_GRP_TALK = 2'h2;
  localparam logic [4:0] GDIS_ADDR_UNIV = 5'h1F;

  // ==========================================================
  // Device-dependent string terminator
  localparam logic [6:0] GDIS_CHAR_LF = 7'h0A;

  // ==========================================================
  // Service request selection bits
  localparam int GDIS_SEL_DONE = 0;
  localparam int GDIS_SEL_FREF = 1;
  localparam int GDIS_SEL_ERR = 2;
  localparam logic [2:0] GDIS_SEL_RESET = 3'h4;

  // ==========================================================
  // Error numbers
  localparam logic [2:0] GDIS_ERR_NONE = 3'h0;
  localparam logic [2:0] GDIS_ERR_PHASE_FREQ = 3'h1;
  localparam logic [2:0] GDIS_ERR_RANGE = 3'h2;
  localparam logic [2:0] GDIS_ERR_OVERFLOW = 3'h3;
  localparam logic [2:0] GDIS_ERR_NUMERIC = 3'h4;
  localparam logic [2:0] GDIS_ERR_SYNTAX = 3'h5;
  localparam logic [2:0] GDIS_ERR_PHASE_HF = 3'h6;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    GDIS_ROLE_IDLE = 2'b00,
    GDIS_ROLE_LISTEN = 2'b01,
    GDIS_ROLE_TALK = 2'b11
  } gdis_role_t;

  // Status byte, bit 7 is data line 8
  typedef struct packed {
    logic gate;
    logic rqs;
    logic err;
    logic rdy;
    logic fref;
    logic [2:0] errnum;
  } gdis_status_t;

  typedef struct packed {
    logic mla;
    logic mta;
    logic ota;
    logic unl;
    logic unt;
    logic llo;
    logic dcl;
    logic sdc;
    logic spe;
    logic spd;
    logic get;
    logic gtl;
  } gdis_msg_t;

  // Events and levels from the measurement engine and command parser
  typedef struct packed {
    logic meas_done;
    logic meas_in_range;
    logic meas_err;
    logic [2:0] meas_err_code;
    logic recall_done;
    logic fref_change;
    logic func_change;
    logic err1_cond;
    logic err6_cond;
    logic num_err;
    logic num_valid;
    logic syntax_err;
    logic cmd_valid;
    logic meas_busy;
    logic gate_open;
  } gdis_engine_t;

endpackage

/* File: verilog/gdis_msg_decode.sv */
// Classifier of multi-line interface messages against the own address
`timescale 1ns/1ps
module gdis_msg_decode import gdis_pkg::*; (
  input wire logic [7:0] data, // Byte on the data lines
  input wire logic atn, // Attention true
  input wire logic [4:0] addr, // Own address
  output gdis_msg_t msg // One-hot message flags
);
  logic [6:0] code;
  logic is_listen;
  logic is_talk;

  always_comb begin
    code = data[6:0];
    is_listen = atn && (code[6:5] == GDIS_GRP_LISTEN) && (code[4:0] != GDIS_ADDR_UNIV);
    is_talk = atn && (code[6:5] == GDIS_GRP_TALK) && (code[4:0] != GDIS_ADDR_UNIV);
    msg = '0;
    msg.mla = is_listen && (code[4:0] == addr);
    msg.mta = is_talk && (code[4:0] == addr);
    msg.ota = is_talk && (code[4:0] != addr);
    msg.unl = atn && (code == GDIS_MSG_UNL);
    msg.unt = atn && (code == GDIS_MSG_UNT);
    msg.llo = atn && (code == GDIS_MSG_LLO);
    msg.dcl = atn && (code == GDIS_MSG_DCL);
    msg.sdc = atn && (code == GDIS_MSG_SDC);
    msg.spe = atn && (code == GDIS_MSG_SPE);
    msg.spd = atn && (code == GDIS_MSG_SPD);
    msg.get = atn && (code == GDIS_MSG_GET);
    msg.gtl = atn && (code == GDIS_MSG_GTL);
  end
endmodule // gdis_msg_decode

/* File: verilog/gdis_core.sv */
// Bus interface state, serial-poll status byte and service request logic
`timescale 1ns/1ps
module gdis_core import gdis_pkg::*; (
  input wire logic mclk, // System clock, 250 MHz
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic [4:0] bus_address_switches, // Rear-panel address
  input wire logic rx_valid, // One pulse per handshaken byte
  input wire logic [7:0] rx_data, // Received byte
  input wire logic rx_atn, // ATN true with the byte
  input wire logic ren, // Remote enable level
  input wire logic tx_taken, // Pulse: controller took talk_byte
  input wire logic out_buf_has_data, // Output buffer holds a string
  input wire logic srq_sel_wr, // Pulse: new service request selection
  input wire logic [2:0] srq_sel_in, // Selection, zero inhibits
  input wire gdis_engine_t eng, // Engine and parser events
  output gdis_role_t role, // Talker or listener role
  output logic remote, // Remote control state
  output logic lockout, // Panel return-to-local disabled
  output logic spoll_mode, // Serial poll mode
  output logic addr_lamp, // Addressed indicator
  output logic srq_out, // Drive the service request line
  output logic trigger, // Pulse: take one measurement
  output logic dev_clear, // Pulse: restore power-up settings
  output logic dd_valid, // Pulse: device-dependent byte to execute
  output logic [7:0] dd_byte, // Device-dependent byte
  output logic talk_valid, // Byte offered to the bus
  output logic [7:0] talk_byte, // Status byte in every role and mode
  output logic talk_status, // Offered byte is the status byte
  output logic result_block, // Measurement string withheld
  output logic [2:0] srq_sel // Active service request selection
);

  // ==========================================================
  // Reset release
  logic [1:0] rst_pipe;
  logic rst_sync_n;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_pipe[1];

  // ==========================================================
  // State
  typedef struct packed {
    gdis_role_t role;
    logic remote;
    logic lockout;
    logic spoll;
    logic [2:0] sel;
    gdis_status_t stat;
    logic skip;
    logic trigger;
    logic dev_clear;
    logic dd_valid;
    logic [7:0] dd_byte;
    logic talk_valid;
    logic [7:0] talk_byte;
    logic talk_status;
    logic result_block;
  } gdis_state_t;

  gdis_state_t st;
  gdis_state_t next_st;
  gdis_msg_t msg;
  logic atn_byte;
  logic dd_rx;
  logic poll_read;
  logic err_raise;
  logic [2:0] err_code;
  logic err_clear;
  logic evt_done;
  logic evt_fref;
  logic any_evt;

  gdis_msg_decode gdis_msg_decode_inst (
    .data(rx_data),
    .atn(rx_atn),
    .addr(bus_address_switches),
    .msg(msg)
  );

  always_comb begin
    next_st = st;
    next_st.trigger = 1'b0;
    next_st.dev_clear = 1'b0;
    next_st.dd_valid = 1'b0;
    atn_byte = rx_valid && rx_atn;
    dd_rx = rx_valid && !rx_atn && (st.role == GDIS_ROLE_LISTEN);
    poll_read = tx_taken && st.talk_status;

    // Addressing; unrecognised ATN bytes fall through untouched
    if (atn_byte) begin
      if (msg.mla) begin
        next_st.role = GDIS_ROLE_LISTEN;
        if (ren) begin
          next_st.remote = 1'b1;
        end
      end else if (msg.mta) begin
        next_st.role = GDIS_ROLE_TALK;
      end else if (msg.ota && st.role == GDIS_ROLE_TALK) begin
        next_st.role = GDIS_ROLE_IDLE;
      end else if (msg.unt && st.role == GDIS_ROLE_TALK) begin
        next_st.role = GDIS_ROLE_IDLE;
      end else if (msg.unl && st.role == GDIS_ROLE_LISTEN) begin
        next_st.role = GDIS_ROLE_IDLE;
      end
      if (msg.llo) begin
        next_st.lockout = 1'b1;
      end
      if (msg.spe) begin
        next_st.spoll = 1'b1;
      end
      if (msg.spd) begin
        next_st.spoll = 1'b0;
      end
      if (msg.gtl && st.role == GDIS_ROLE_LISTEN) begin
        next_st.remote = 1'b0;
      end
      if (msg.get && st.role == GDIS_ROLE_LISTEN && !eng.meas_busy) begin
        next_st.trigger = 1'b1;
      end
      // Device clear touches settings only, never the bus state
      if ((msg.dcl && st.remote) || (msg.sdc && st.remote && st.role == GDIS_ROLE_LISTEN)) begin
        next_st.dev_clear = 1'b1;
        next_st.sel = GDIS_SEL_RESET;
      end
    end

    // Device-dependent bytes; after a syntax error they are swallowed
    if (dd_rx) begin
      if (ren) begin
        next_st.remote = 1'b1;
      end
      next_st.dd_valid = !st.skip;
      next_st.dd_byte = rx_data;
      if (rx_data[6:0] == GDIS_CHAR_LF) begin
        next_st.skip = 1'b0;
      end
    end
    if (eng.syntax_err) begin
      next_st.skip = 1'b1;
    end

    // Lockout is only left by the controller dropping REN
    if (!ren) begin
      next_st.remote = 1'b0;
      next_st.lockout = 1'b0;
    end

    if (srq_sel_wr) begin
      next_st.sel = srq_sel_in;
    end

    // Error number: clears first so that a new error in the same cycle wins
    err_clear = 1'b0;
    case (st.stat.errnum)
      GDIS_ERR_PHASE_FREQ: err_clear = !eng.err1_cond || eng.func_change;
      GDIS_ERR_RANGE,
      GDIS_ERR_OVERFLOW: err_clear = eng.meas_done && eng.meas_in_range;
      GDIS_ERR_NUMERIC: err_clear = eng.num_valid;
      GDIS_ERR_SYNTAX: err_clear = eng.cmd_valid;
      GDIS_ERR_PHASE_HF: err_clear = !eng.err6_cond || eng.func_change;
      default: err_clear = 1'b0;
    endcase
    if (err_clear) begin
      next_st.stat.errnum = GDIS_ERR_NONE;
    end
    err_raise = 1'b1;
    err_code = GDIS_ERR_NONE;
    if (eng.syntax_err) begin
      err_code = GDIS_ERR_SYNTAX;
    end else if (eng.num_err) begin
      err_code = GDIS_ERR_NUMERIC;
    end else if (eng.meas_err) begin
      err_code = eng.meas_err_code;
    end else begin
      err_raise = 1'b0;
    end
    if (err_raise) begin
      next_st.stat.errnum = err_code;
    end
    next_st.stat.err = (next_st.stat.errnum != GDIS_ERR_NONE);

    // Status events; a recall never counts as a fresh reading
    evt_done = eng.meas_done && !eng.recall_done;
    evt_fref = eng.fref_change;
    any_evt = (st.sel[GDIS_SEL_DONE] && evt_done) || (st.sel[GDIS_SEL_FREF] && evt_fref) ||
      (st.sel[GDIS_SEL_ERR] && err_raise);
    if (poll_read) begin
      next_st.stat.fref = 1'b0;
      next_st.stat.rdy = 1'b0;
      next_st.stat.rqs = 1'b0;
    end
    if (evt_fref) begin
      next_st.stat.fref = 1'b1;
    end
    if (evt_done) begin
      next_st.stat.rdy = 1'b1;
    end
    if (any_evt) begin
      next_st.stat.rqs = 1'b1;
    end
    next_st.stat.gate = eng.gate_open;

    // Talker output
    next_st.result_block = (next_st.stat.errnum == GDIS_ERR_PHASE_FREQ) ||
      (next_st.stat.errnum == GDIS_ERR_RANGE) || (next_st.stat.errnum == GDIS_ERR_OVERFLOW);
    next_st.talk_status = (next_st.role == GDIS_ROLE_TALK) && next_st.spoll;
    next_st.talk_byte = next_st.stat;
    next_st.talk_valid = next_st.talk_status || ((next_st.role == GDIS_ROLE_TALK) &&
      out_buf_has_data && !next_st.result_block);
  end

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      st <= '0;
      st.sel <= GDIS_SEL_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign role = st.role;
  assign remote = st.remote;
  assign lockout = st.lockout;
  assign spoll_mode = st.spoll;
  // Idle is the only role with bit 0 low, so the lamp is a plain flop bit
  assign addr_lamp = st.role[0];
  assign srq_out = st.stat.rqs;
  assign trigger = st.trigger;
  assign dev_clear = st.dev_clear;
  assign dd_valid = st.dd_valid;
  assign dd_byte = st.dd_byte;
  assign talk_valid = st.talk_valid;
  assign talk_byte = st.talk_byte;
  assign talk_status = st.talk_status;
  assign result_block = st.result_block;
  assign srq_sel = st.sel;

  // ==========================================================
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_sync_n);

  a_listen_addr: assert property (rx_valid && rx_atn && msg.mla && ren |=>
    role == GDIS_ROLE_LISTEN && remote) else $error("listen address not taken");
  a_talk_addr: assert property (rx_valid && rx_atn && msg.mta |=>
    role == GDIS_ROLE_TALK && addr_lamp) else $error("talk address not taken");
  a_other_talk: assert property (rx_valid && rx_atn && msg.ota && role == GDIS_ROLE_TALK |=>
    role == GDIS_ROLE_IDLE) else $error("talker kept after other talk address");
  a_ren_drop: assert property (!ren |=> !remote && !lockout)
    else $error("REN false did not return to local");
  a_get_gate: assert property (rx_valid && rx_atn && msg.get |=>
    trigger == ($past(role) == GDIS_ROLE_LISTEN && !$past(eng.meas_busy)))
    else $error("trigger does not follow GET conditions");
  a_dcl_local: assert property (rx_valid && rx_atn && msg.dcl && !remote |=> !dev_clear)
    else $error("device clear accepted in local");
  a_err_overwrite: assert property (eng.syntax_err |=> talk_byte[2:0] == GDIS_ERR_SYNTAX
    && talk_byte[5]) else $error("syntax error not stored");
  a_poll_release: assert property (tx_taken && talk_status && !eng.meas_done && !eng.fref_change
    && !eng.meas_err && !eng.num_err && !eng.syntax_err |=> !srq_out)
    else $error("SRQ held after status read");
  a_poll_talk: assert property (role == GDIS_ROLE_TALK && spoll_mode
    |-> talk_status && talk_valid) else $error("status byte not offered in poll");
  a_unl_idle: assert property (rx_valid && rx_atn && msg.unl && role == GDIS_ROLE_LISTEN |=>
    role == GDIS_ROLE_IDLE && !addr_lamp) else $error("listener kept after unlisten");
  a_recall_quiet: assert property (eng.recall_done && !srq_out && !eng.fref_change
    && !eng.meas_err && !eng.num_err && !eng.syntax_err && !tx_taken |=> !srq_out)
    else $error("SRQ raised after recall");

endmodule // gdis_core

/* File: verif/gdis_ctrl_model.sv */
// Bus controller model: sends bytes, drives remote enable, takes talked bytes
`timescale 1ns/1ps
module gdis_ctrl_model (
  input wire logic mclk, // System clock
  output logic rx_valid, // Byte handshaken
  output logic [7:0] rx_data, // Byte on the data lines
  output logic rx_atn, // Attention with the byte
  output logic ren, // Remote enable level
  output logic tx_taken // Talked byte accepted
);
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_atn = 1'b0;
    ren = 1'b0;
    tx_taken = 1'b0;
  end

  // ==========================================================
  // Byte transfer
  // Released lines show the inverse so a stale byte never looks valid
  task automatic send(input logic atn, input logic [7:0] b);
    @(negedge mclk);
    rx_atn = atn;
    rx_data = b;
    rx_valid = 1'b1;
    @(negedge mclk);
    rx_valid = 1'b0;
    rx_data = ~b;
    rx_atn = ~atn;
  endtask

  // ==========================================================
  // Remote enable and poll read
  task automatic set_ren(input logic v);
    @(negedge mclk);
    ren = v;
  endtask

  task automatic take();
    @(negedge mclk);
    tx_taken = 1'b1;
    @(negedge mclk);
    tx_taken = 1'b0;
  endtask
endmodule // gdis_ctrl_model

/* File: verif/gdis_device_interface_status_bench.sv */
// Self-checking bench of the bus interface and status block
`timescale 1ns/1ps
module gdis_device_interface_status_bench import gdis_pkg::*;;
  localparam logic [4:0] MY = 5'h0A;
  logic mclk, rst_n, rx_valid, rx_atn, ren, tx_taken, out_buf, sel_wr;
  logic remote, lockout, spoll_mode, addr_lamp, srq_out, trigger, dev_clear, dd_valid;
  logic talk_valid, talk_status, result_block;
  logic [7:0] rx_data, dd_byte, talk_byte, dd_last;
  logic [4:0] addr_sw;
  logic [2:0] sel_in, srq_sel;
  gdis_engine_t eng, lv;
  gdis_role_t role;
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;
  int dd_n = 0;
  int trig_n = 0;
  int dev_n = 0;

  gdis_ctrl_model gdis_ctrl_model_inst (.mclk(mclk), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_atn(rx_atn), .ren(ren), .tx_taken(tx_taken));

  gdis_core gdis_core_inst (.mclk(mclk), .rst_n(rst_n), .bus_address_switches(addr_sw),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_atn(rx_atn), .ren(ren), .tx_taken(tx_taken),
    .out_buf_has_data(out_buf), .srq_sel_wr(sel_wr), .srq_sel_in(sel_in), .eng(eng),
    .role(role), .remote(remote), .lockout(lockout), .spoll_mode(spoll_mode),
    .addr_lamp(addr_lamp), .srq_out(srq_out), .trigger(trigger), .dev_clear(dev_clear),
    .dd_valid(dd_valid), .dd_byte(dd_byte), .talk_valid(talk_valid), .talk_byte(talk_byte),
    .talk_status(talk_status), .result_block(result_block), .srq_sel(srq_sel));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // ==========================================================
  // Pulse counting at the falling edge, where registered outputs are settled
  always @(negedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      print_verdict();
    end
    if (dd_valid === 1'b1) begin
      dd_n++;
      dd_last = dd_byte;
    end
    if (trigger === 1'b1) trig_n++;
    if (dev_clear === 1'b1) dev_n++;
  end

  // ==========================================================
  // Helpers
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic w(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic tx(input logic atn, input logic [7:0] b);
    gdis_ctrl_model_inst.send(atn, b);
    w(2);
  endtask

  task automatic take();
    gdis_ctrl_model_inst.take();
    w(2);
  endtask

  task automatic pulse(input gdis_engine_t p);
    @(negedge mclk);
    eng = lv | p;
    @(negedge mclk);
    eng = lv;
    w(2);
  endtask

  task automatic level(input gdis_engine_t v);
    @(negedge mclk);
    lv = v;
    eng = v;
    w(2);
  endtask

  task automatic sel(input logic [2:0] v);
    @(negedge mclk);
    sel_wr = 1'b1;
    sel_in = v;
    @(negedge mclk);
    sel_wr = 1'b0;
    w(2);
  endtask

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    rst_n = 1'b0;
    out_buf = 1'b0;
    sel_wr = 1'b0;
    sel_in = 3'h0;
    lv = '0;
    eng = '0;
    addr_sw = MY;
    w(3);
    rst_n = 1'b1;
    w(4);
    chk(16'(srq_sel), 16'(GDIS_SEL_RESET));
    gdis_ctrl_model_inst.set_ren(1'b1);
    tx(1'b1, {3'h1, MY});
    chk(16'({role, remote, addr_lamp}), 16'h7);
    tx(1'b0, 8'h41);
    chk(16'(dd_last), 16'h41);
    tx(1'b1, 8'h0F);
    chk(16'({role, remote, addr_lamp, 8'(dd_n)}), 16'h701);
    tx(1'b1, {1'b0, GDIS_MSG_GET});
    level('{meas_busy: 1'b1, default: '0});
    tx(1'b1, {1'b0, GDIS_MSG_GET});
    chk(16'(trig_n), 16'h1);
    level('0);
    sel(3'h7);
    tx(1'b1, {1'b0, GDIS_MSG_SDC});
    chk(16'({srq_sel, role, remote, addr_lamp, 8'(dev_n)}), 16'h4701);
    tx(1'b1, {1'b0, GDIS_MSG_GTL});
    chk(16'({role, remote, addr_lamp}), 16'h5);
    tx(1'b1, {1'b0, GDIS_MSG_DCL});
    chk(16'(dev_n), 16'h1);
    tx(1'b0, 8'h42);
    chk(16'({role, remote, addr_lamp}), 16'h7);
    tx(1'b1, {1'b0, GDIS_MSG_DCL});
    chk(16'(dev_n), 16'h2);
    pulse('{syntax_err: 1'b1, default: '0});
    tx(1'b0, 8'h43);
    tx(1'b0, {1'b0, GDIS_CHAR_LF});
    chk(16'(dd_n), 16'h2);
    tx(1'b0, 8'h44);
    chk(16'(dd_last), 16'h44);
    pulse('{cmd_valid: 1'b1, default: '0});
    tx(1'b1, {1'b0, GDIS_MSG_LLO});
    chk(16'(lockout), 16'h1);
    gdis_ctrl_model_inst.set_ren(1'b0);
    w(2);
    chk(16'({lockout, remote}), 16'h0);
    tx(1'b1, {3'h2, MY});
    chk(16'({role, remote}), 16'h6);
    tx(1'b1, {3'h2, 5'h0B});
    chk(16'(role), 16'(GDIS_ROLE_IDLE));
    gdis_ctrl_model_inst.set_ren(1'b1);
    tx(1'b1, {3'h1, MY});
    tx(1'b1, {1'b0, GDIS_MSG_UNL});
    chk(16'({role, addr_lamp}), 16'h0);
    tx(1'b0, 8'h45);
    chk(16'(dd_n), 16'h3);
    tx(1'b1, {3'h2, MY});
    tx(1'b1, {1'b0, GDIS_MSG_UNT});
    chk(16'({role, addr_lamp}), 16'h0);
    // Poll as talker: talk_byte then tracks the status byte
    tx(1'b1, {1'b0, GDIS_MSG_SPE});
    tx(1'b1, {3'h2, MY});
    chk(16'({spoll_mode, talk_status, talk_valid, talk_byte}), 16'h740);
    sel(3'h1);
    pulse('{meas_done: 1'b1, meas_in_range: 1'b1, default: '0});
    chk(16'({srq_out, talk_byte}), 16'h150);
    take();
    chk(16'({srq_out, talk_byte}), 16'h000);
    pulse('{meas_done: 1'b1, meas_in_range: 1'b1, recall_done: 1'b1, default: '0});
    chk(16'({srq_out, talk_byte}), 16'h000);
    sel(3'h2);
    pulse('{fref_change: 1'b1, default: '0});
    chk(16'({srq_out, talk_byte}), 16'h148);
    take();
    sel(3'h0);
    pulse('{meas_err: 1'b1, meas_err_code: GDIS_ERR_RANGE, default: '0});
    chk(16'({result_block, srq_out, talk_byte}), 16'h222);
    pulse('{meas_done: 1'b1, meas_in_range: 1'b1, default: '0});
    chk(16'({srq_out, talk_byte}), 16'h010);
    take();
    pulse('{meas_err: 1'b1, meas_err_code: GDIS_ERR_OVERFLOW, default: '0});
    chk(16'(talk_byte), 16'h23);
    pulse('{num_err: 1'b1, default: '0});
    chk(16'(talk_byte), 16'h24);
    pulse('{num_valid: 1'b1, default: '0});
    chk(16'(talk_byte), 16'h00);
    pulse('{syntax_err: 1'b1, default: '0});
    chk(16'(talk_byte), 16'h25);
    pulse('{cmd_valid: 1'b1, default: '0});
    chk(16'(talk_byte), 16'h00);
    level('{err6_cond: 1'b1, default: '0});
    pulse('{meas_err: 1'b1, meas_err_code: GDIS_ERR_PHASE_HF, default: '0});
    w(4);
    chk(16'(talk_byte), 16'h26);
    level('0);
    chk(16'(talk_byte), 16'h00);
    level('{err1_cond: 1'b1, default: '0});
    pulse('{meas_err: 1'b1, meas_err_code: GDIS_ERR_PHASE_FREQ, default: '0});
    chk(16'({result_block, talk_byte}), 16'h121);
    pulse('{func_change: 1'b1, default: '0});
    chk(16'({result_block, talk_byte}), 16'h000);
    level('0);
    sel(3'h4);
    level('{gate_open: 1'b1, default: '0});
    pulse('{num_err: 1'b1, default: '0});
    chk(16'({srq_out, talk_byte}), 16'h1E4);
    take();
    chk(16'({srq_out, talk_byte}), 16'h0A4);
    level('0);
    pulse('{num_valid: 1'b1, default: '0});
    tx(1'b1, {1'b0, GDIS_MSG_SPD});
    chk(16'({spoll_mode, talk_status, talk_valid}), 16'h0);
    @(negedge mclk);
    out_buf = 1'b1;
    w(2);
    chk(16'({spoll_mode, talk_status, talk_valid}), 16'h1);
    print_verdict();
  end
endmodule // gdis_device_interface_status_bench
